/* File: rtl/conveyor_motor_status_inputs.sv */
`timescale 1ns/10ps
// What this block does
// - Sensor word bit 0 marks right port device, bit 1 left port device.
// - Sensor word is read-only; controller writes never change it.
// - Supply word gives millivolts, clamped to 0 through 35000.
// - Left and right current words give drawn current in milliamperes.
// - Left and right frequency words give running frequency in hertz.
// - Temperature word upper byte holds calculated motor temperature.
// - Temperature word lower byte holds on-board sensor temperature.
// - Status bits 0 and 1 form a two-bit motor status code.
// - Status bit 2 marks port configured as digital input/output.
// - Left status bit 5 flags board overheat; bits 3, 4 read zero.
// - Status bit 6 flags over-voltage, bit 7 low voltage.
// - Status bit 8 flags motor overheated, bit 9 maximum torque.
// - Status bit 10 flags a short circuit.
// - Status bit 11 flags no motor attached.
// - Status bit 12 flags overload, bit 13 stalled motor.
// - Status bit 14 flags a hall sensor fault.
// - Status bit 15 flags port configured as unused.
// - Byte mapping puts upper byte at lower index, lower byte next.
// - Every word is a 16-bit integer.
module conveyor_motor_status_inputs
   import conveyor_inputs_pkg::*;
#(
   parameter logic [15:0] REFRESH_CYCLES = SAMPLE_CYCLES
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic SENSOR_RIGHT_PRESENT,
   input wire logic SENSOR_LEFT_PRESENT,
   input wire logic [15:0] SUPPLY_MV,
   input wire logic [15:0] LEFT_MA,
   input wire logic [15:0] LEFT_HZ,
   input wire logic [7:0] LEFT_MOTOR_DEGC,
   input wire logic [7:0] LEFT_BOARD_DEGC,
   input wire logic [1:0] LEFT_STATUS_CODE,
   input wire logic LEFT_DIGITAL_MODE,
   input wire logic BOARD_OVERHEAT,
   input wire logic LEFT_OVER_VOLT,
   input wire logic LEFT_LOW_VOLT,
   input wire logic LEFT_MOTOR_HOT,
   input wire logic LEFT_MAX_TORQUE,
   input wire logic LEFT_SHORT,
   input wire logic LEFT_NOT_CONNECTED,
   input wire logic LEFT_OVERLOAD,
   input wire logic LEFT_STALLED,
   input wire logic LEFT_HALL_FAULT,
   input wire logic LEFT_NOT_USED,
   input wire logic [15:0] RIGHT_MA,
   input wire logic [15:0] RIGHT_HZ,
   input wire logic [7:0] RIGHT_MOTOR_DEGC,
   input wire logic [7:0] RIGHT_BOARD_DEGC,
   input wire logic RD_STB,
   input wire logic MAP_ETHERNET,
   input wire logic [15:0] RD_ADDR,
   input wire logic WR_STB,
   input wire logic [15:0] WR_ADDR,
   input wire logic BYTE_STB,
   input wire logic [7:0] BYTE_IDX,
   output logic [15:0] RD_DATA,
   output logic RD_VALID,
   output logic RD_ERR,
   output logic WR_ERR,
   output logic [7:0] BYTE_DATA,
   output logic BYTE_VALID,
   output logic BYTE_ERR
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef logic [NUM_WORDS-1:0][15:0] word_array_t;

   typedef struct packed {
      logic [15:0] tick_cnt;
      word_array_t words;
      logic [15:0] rd_data;
      logic rd_valid;
      logic rd_err;
      logic wr_err;
      logic [7:0] byte_data;
      logic byte_valid;
      logic byte_err;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [15:0] left_fault_word;
   logic tick;
   logic [4:0] rd_slot;
   logic [4:0] wr_slot;
   logic [4:0] byte_slot;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Returns {hit, index} for an offset counted from the first word.
   function automatic logic [4:0] slot_of(input logic [15:0] rel);
      logic [4:0] r;
      r = 5'h00;
      if (rel < 16'(NUM_WORDS)) begin
         r = {1'b1, rel[3:0]};
      end
      return r;
   endfunction

   function automatic logic [15:0] clamp_mv(input logic [15:0] mv);
      logic [15:0] r;
      r = (mv > SUPPLY_MAX_MV) ? SUPPLY_MAX_MV : mv;
      return r;
   endfunction

   motor_fault_word #(
      .HAS_BOARD_FLAG(1'b1)
   ) u_left_faults (
      .status_code(LEFT_STATUS_CODE),
      .digital_mode(LEFT_DIGITAL_MODE),
      .board_hot(BOARD_OVERHEAT),
      .over_volt(LEFT_OVER_VOLT),
      .low_volt(LEFT_LOW_VOLT),
      .motor_hot(LEFT_MOTOR_HOT),
      .max_torque(LEFT_MAX_TORQUE),
      .short_circuit(LEFT_SHORT),
      .not_connected(LEFT_NOT_CONNECTED),
      .overload(LEFT_OVERLOAD),
      .stalled(LEFT_STALLED),
      .hall_fault(LEFT_HALL_FAULT),
      .not_used(LEFT_NOT_USED),
      .word(left_fault_word)
   );

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   // The Ethernet index and the register number differ only by their base.
   assign rd_slot = MAP_ETHERNET ?
                    slot_of(RD_ADDR - EIP_FIRST_INDEX) :
                    slot_of(RD_ADDR - SENSOR_PRESENCE_OFS);
   assign wr_slot = slot_of(WR_ADDR - SENSOR_PRESENCE_OFS);
   assign byte_slot = (BYTE_IDX < PN_FIRST_BYTE) ? 5'h00 :
                      slot_of({8'h00, 1'b0, 7'((BYTE_IDX - PN_FIRST_BYTE) >> 1)});
   assign tick = (st_reg.tick_cnt == REFRESH_CYCLES - 16'h0001);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.tick_cnt = tick ? 16'h0000 : st_reg.tick_cnt + 16'h0001;
      // A snapshot is taken on each tick so a word never mixes two samples.
      if (tick) begin
         st_next.words[0] = WORD_RESET;
         st_next.words[0][SENSE_RIGHT_BIT] = SENSOR_RIGHT_PRESENT;
         st_next.words[0][SENSE_LEFT_BIT] = SENSOR_LEFT_PRESENT;
         st_next.words[1] = clamp_mv(SUPPLY_MV);
         st_next.words[2] = LEFT_MA;
         st_next.words[3] = LEFT_HZ;
         st_next.words[4] = {LEFT_MOTOR_DEGC, LEFT_BOARD_DEGC};
         st_next.words[5] = left_fault_word;
         st_next.words[6] = RIGHT_MA;
         st_next.words[7] = RIGHT_HZ;
         st_next.words[8] = {RIGHT_MOTOR_DEGC, RIGHT_BOARD_DEGC};
      end
      // Writes never reach the words; a write is answered with an error only.
      st_next.wr_err = WR_STB;
      st_next.rd_valid = RD_STB;
      st_next.rd_err = RD_STB & ~rd_slot[4];
      st_next.rd_data = WORD_RESET;
      if (RD_STB && rd_slot[4]) begin
         st_next.rd_data = st_reg.words[rd_slot[3:0]];
      end
      st_next.byte_valid = BYTE_STB;
      st_next.byte_err = BYTE_STB & ~byte_slot[4];
      st_next.byte_data = 8'h00;
      if (BYTE_STB && byte_slot[4]) begin
         st_next.byte_data = BYTE_IDX[0] ? st_reg.words[byte_slot[3:0]][7:0] :
                                           st_reg.words[byte_slot[3:0]][15:8];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign RD_DATA = st_reg.rd_data;
   assign RD_VALID = st_reg.rd_valid;
   assign RD_ERR = st_reg.rd_err;
   assign WR_ERR = st_reg.wr_err;
   assign BYTE_DATA = st_reg.byte_data;
   assign BYTE_VALID = st_reg.byte_valid;
   assign BYTE_ERR = st_reg.byte_err;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);

   sense_bits_a: assert property (tick |=> st_reg.words[0] ==
      {14'h0000, $past(SENSOR_LEFT_PRESENT), $past(SENSOR_RIGHT_PRESENT)})
      else $error("sensor word does not match ports");
   write_ignored_a: assert property (WR_STB && !tick |=>
      st_reg.words == $past(st_reg.words) && WR_ERR)
      else $error("write altered a word");
   supply_clamp_a: assert property (st_reg.words[1] <= SUPPLY_MAX_MV)
      else $error("supply word above limit");
   supply_pass_a: assert property (tick && SUPPLY_MV <= SUPPLY_MAX_MV |=>
      st_reg.words[1] == $past(SUPPLY_MV))
      else $error("supply word not taken");
   current_words_a: assert property (tick |=>
      st_reg.words[2] == $past(LEFT_MA) && st_reg.words[6] == $past(RIGHT_MA))
      else $error("current word stale");
   freq_words_a: assert property (tick |=>
      st_reg.words[3] == $past(LEFT_HZ) && st_reg.words[7] == $past(RIGHT_HZ))
      else $error("frequency word stale");
   motor_temp_a: assert property (tick |=>
      st_reg.words[4][15:8] == $past(LEFT_MOTOR_DEGC))
      else $error("motor temperature byte wrong");
   board_temp_a: assert property (tick |=>
      st_reg.words[8][7:0] == $past(RIGHT_BOARD_DEGC))
      else $error("board temperature byte wrong");
   status_code_a: assert property (tick |=>
      st_reg.words[5][1:0] == $past(LEFT_STATUS_CODE))
      else $error("status code wrong");
   digital_flag_a: assert property (tick |=>
      st_reg.words[5][DIGITAL_MODE_BIT] == $past(LEFT_DIGITAL_MODE))
      else $error("digital mode bit wrong");
   board_flag_a: assert property (tick |=>
      st_reg.words[5][5:3] == {$past(BOARD_OVERHEAT), 2'b00})
      else $error("board overheat or reserved bits wrong");
   volt_flags_a: assert property (tick |=>
      st_reg.words[5][7:6] == {$past(LEFT_LOW_VOLT), $past(LEFT_OVER_VOLT)})
      else $error("voltage flags wrong");
   hot_torque_a: assert property (tick |=>
      st_reg.words[5][9:8] == {$past(LEFT_MAX_TORQUE), $past(LEFT_MOTOR_HOT)})
      else $error("heat or torque flag wrong");
   short_flag_a: assert property (tick |=>
      st_reg.words[5][SHORT_BIT] == $past(LEFT_SHORT))
      else $error("short circuit flag wrong");
   absent_flag_a: assert property (tick |=>
      st_reg.words[5][NOT_CONNECTED_BIT] == $past(LEFT_NOT_CONNECTED))
      else $error("not connected flag wrong");
   load_stall_a: assert property (tick |=>
      st_reg.words[5][13:12] == {$past(LEFT_STALLED), $past(LEFT_OVERLOAD)})
      else $error("overload or stall flag wrong");
   hall_flag_a: assert property (tick |=>
      st_reg.words[5][HALL_FAULT_BIT] == $past(LEFT_HALL_FAULT))
      else $error("hall fault flag wrong");
   unused_flag_a: assert property (tick |=>
      st_reg.words[5][NOT_USED_BIT] == $past(LEFT_NOT_USED))
      else $error("unused port flag wrong");
   byte_order_a: assert property (BYTE_STB && byte_slot[4] && !tick |=>
      BYTE_DATA == ($past(BYTE_IDX[0]) ? st_reg.words[$past(byte_slot[3:0])][7:0] :
                    st_reg.words[$past(byte_slot[3:0])][15:8]))
      else $error("byte order wrong");
   read_word_a: assert property (RD_STB && rd_slot[4] && !tick |=>
      RD_VALID && !RD_ERR && RD_DATA == st_reg.words[$past(rd_slot[3:0])])
      else $error("word read wrong");
   refresh_due_a: assert property (st_reg.tick_cnt < REFRESH_CYCLES)
      else $error("refresh counter overran");
   sensor_upper_a: assert property (st_reg.words[0][15:2] == 14'h0000)
      else $error("sensor word upper bits set");
   supply_clip_a: assert property (tick && SUPPLY_MV > SUPPLY_MAX_MV |=>
      st_reg.words[1] == SUPPLY_MAX_MV)
      else $error("supply word not clamped");
   left_board_temp_a: assert property (tick |=>
      st_reg.words[4][7:0] == $past(LEFT_BOARD_DEGC))
      else $error("left board temperature byte wrong");
   right_motor_temp_a: assert property (tick |=>
      st_reg.words[8][15:8] == $past(RIGHT_MOTOR_DEGC))
      else $error("right motor temperature byte wrong");
   reserved_zero_a: assert property (st_reg.words[5][RSVD_HI_BIT:RSVD_LO_BIT] == 2'b00)
      else $error("reserved status bits set");
   words_hold_a: assert property (!tick |=> st_reg.words == $past(st_reg.words))
      else $error("word changed between refresh ticks");
   refresh_wrap_a: assert property (tick |=> st_reg.tick_cnt == 16'h0000)
      else $error("refresh counter did not restart");
   reg_map_a: assert property (RD_STB && !MAP_ETHERNET && !tick &&
      RD_ADDR == LEFT_MOTOR_FAULTS_OFS |=> RD_DATA == st_reg.words[5])
      else $error("register number decode wrong");
   index_map_a: assert property (RD_STB && MAP_ETHERNET && !tick &&
      RD_ADDR == EIP_FIRST_INDEX + 16'h0008 |=> RD_DATA == st_reg.words[8])
      else $error("input index decode wrong");
   byte_map_a: assert property (BYTE_STB && !tick &&
      BYTE_IDX == PN_FIRST_BYTE + 8'h02 |=> BYTE_DATA == st_reg.words[1][15:8])
      else $error("byte index decode wrong");
   read_refused_a: assert property (RD_STB && !rd_slot[4] |=>
      RD_VALID && RD_ERR && RD_DATA == WORD_RESET)
      else $error("unmapped read not refused");
   byte_refused_a: assert property (BYTE_STB && !byte_slot[4] |=>
      BYTE_VALID && BYTE_ERR && BYTE_DATA == 8'h00)
      else $error("unmapped byte not refused");
   read_idle_a: assert property (!RD_STB |=>
      !RD_VALID && !RD_ERR && RD_DATA == WORD_RESET)
      else $error("read answer without request");
   byte_idle_a: assert property (!BYTE_STB |=>
      !BYTE_VALID && !BYTE_ERR && BYTE_DATA == 8'h00)
      else $error("byte answer without request");
   write_answer_a: assert property (!WR_STB |=> !WR_ERR)
      else $error("write refusal without request");

   read_seen_c: cover property (RD_STB && rd_slot[4] ##1 RD_VALID);
   byte_seen_c: cover property (BYTE_STB && BYTE_IDX[0] ##1 BYTE_VALID);
   write_seen_c: cover property (WR_STB && wr_slot[4] ##1 WR_ERR);
   unmapped_c: cover property (RD_STB && !rd_slot[4] ##1 RD_ERR);
   clamp_seen_c: cover property (tick && SUPPLY_MV > SUPPLY_MAX_MV);

endmodule

/* File: rtl/conveyor_inputs_pkg.sv */
package conveyor_inputs_pkg;

   // ------------------------------------------------------------
   // Word geometry
   // ------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int NUM_WORDS = 9;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // ------------------------------------------------------------
   // Holding-register numbers of the words, in map order
   // ------------------------------------------------------------
   localparam logic [15:0] SENSOR_PRESENCE_OFS = 16'h06A6;
   localparam logic [15:0] SUPPLY_MILLIVOLTS_OFS = 16'h06A7;
   localparam logic [15:0] LEFT_MOTOR_MILLIAMPS_OFS = 16'h06A8;
   localparam logic [15:0] LEFT_MOTOR_HERTZ_OFS = 16'h06A9;
   localparam logic [15:0] LEFT_MOTOR_TEMPERATURES_OFS = 16'h06AA;
   localparam logic [15:0] LEFT_MOTOR_FAULTS_OFS = 16'h06AB;
   localparam logic [15:0] RIGHT_MOTOR_MILLIAMPS_OFS = 16'h06AC;
   localparam logic [15:0] RIGHT_MOTOR_HERTZ_OFS = 16'h06AD;
   localparam logic [15:0] RIGHT_MOTOR_TEMPERATURES_OFS = 16'h06AE;

   // ------------------------------------------------------------
   // Position of the first word in the two other mappings
   // ------------------------------------------------------------
   localparam logic [15:0] EIP_FIRST_INDEX = 16'h0002;
   localparam logic [7:0] PN_FIRST_BYTE = 8'h04;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int SENSE_RIGHT_BIT = 0;
   localparam int SENSE_LEFT_BIT = 1;
   localparam int STAT_CODE_LSB = 0;
   localparam int DIGITAL_MODE_BIT = 2;
   localparam int RSVD_LO_BIT = 3;
   localparam int RSVD_HI_BIT = 4;
   localparam int BOARD_HOT_BIT = 5;
   localparam int OVER_VOLT_BIT = 6;
   localparam int LOW_VOLT_BIT = 7;
   localparam int MOTOR_HOT_BIT = 8;
   localparam int MAX_TORQUE_BIT = 9;
   localparam int SHORT_BIT = 10;
   localparam int NOT_CONNECTED_BIT = 11;
   localparam int OVERLOAD_BIT = 12;
   localparam int STALL_BIT = 13;
   localparam int HALL_FAULT_BIT = 14;
   localparam int NOT_USED_BIT = 15;

   // ------------------------------------------------------------
   // Limits and timing
   // ------------------------------------------------------------
   localparam logic [15:0] SUPPLY_MAX_MV = 16'h88B8;
   localparam int CLK_PERIOD_NS = 40;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES_CALC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [15:0] SAMPLE_CYCLES = SAMPLE_CYCLES_CALC[15:0];

endpackage

/* File: rtl/motor_fault_word.sv */
`timescale 1ns/10ps
module motor_fault_word
   import conveyor_inputs_pkg::*;
#(
   parameter bit HAS_BOARD_FLAG = 1'b1
) (
   input wire logic [1:0] status_code,
   input wire logic digital_mode,
   input wire logic board_hot,
   input wire logic over_volt,
   input wire logic low_volt,
   input wire logic motor_hot,
   input wire logic max_torque,
   input wire logic short_circuit,
   input wire logic not_connected,
   input wire logic overload,
   input wire logic stalled,
   input wire logic hall_fault,
   input wire logic not_used,
   output logic [15:0] word
);

   // ------------------------------------------------------------
   // Status word assembly
   // ------------------------------------------------------------
   always_comb begin
      word = WORD_RESET;
      word[STAT_CODE_LSB +: 2] = status_code;
      word[DIGITAL_MODE_BIT] = digital_mode;
      // Only the left port carries the board flag; bits 3 and 4 stay zero.
      word[BOARD_HOT_BIT] = HAS_BOARD_FLAG & board_hot;
      word[OVER_VOLT_BIT] = over_volt;
      word[LOW_VOLT_BIT] = low_volt;
      word[MOTOR_HOT_BIT] = motor_hot;
      word[MAX_TORQUE_BIT] = max_torque;
      word[SHORT_BIT] = short_circuit;
      word[NOT_CONNECTED_BIT] = not_connected;
      word[OVERLOAD_BIT] = overload;
      word[STALL_BIT] = stalled;
      word[HALL_FAULT_BIT] = hall_fault;
      word[NOT_USED_BIT] = not_used;
   end

endmodule

/* File: dv/plc_poller.sv */
`timescale 1ns/10ps
module plc_poller (
   input wire logic clk,
   output logic rd_stb,
   output logic map_ethernet,
   output logic [15:0] rd_addr,
   output logic wr_stb,
   output logic [15:0] wr_addr,
   output logic byte_stb,
   output logic [7:0] byte_idx,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_err,
   input wire logic wr_err,
   input wire logic [7:0] byte_data,
   input wire logic byte_valid,
   input wire logic byte_err
);
   initial begin
      rd_stb = 1'b0;
      map_ethernet = 1'b0;
      rd_addr = 16'h0000;
      wr_stb = 1'b0;
      wr_addr = 16'h0000;
      byte_stb = 1'b0;
      byte_idx = 8'h00;
   end
   // ------------------------------------------------------------
   // One poll: 0 word by number, 1 word by index, 2 write, 3 byte.
   // ------------------------------------------------------------
   task automatic xfer(input logic [1:0] kind, input logic [15:0] addr,
                       output logic [15:0] data, output logic err, output bit ok);
      int i;
      ok = 1'b0;
      data = 16'h0000;
      err = 1'b0;
      @(posedge clk);
      case (kind)
         2'h0, 2'h1: begin
            map_ethernet <= kind[0];
            rd_addr <= addr;
            rd_stb <= 1'b1;
         end
         2'h2: begin
            wr_addr <= addr;
            wr_stb <= 1'b1;
         end
         default: begin
            byte_idx <= addr[7:0];
            byte_stb <= 1'b1;
         end
      endcase
      @(posedge clk);
      rd_stb <= 1'b0;
      wr_stb <= 1'b0;
      byte_stb <= 1'b0;
      // Released lines show the inverse, so a stale address never reads as valid.
      rd_addr <= ~addr;
      wr_addr <= ~addr;
      byte_idx <= ~addr[7:0];
      for (i = 0; i < 4 && !ok; i++) begin
         @(posedge clk);
         if (kind[1] == 1'b0 && rd_valid === 1'b1) begin
            data = rd_data;
            err = rd_err;
            ok = 1'b1;
         end else if (kind == 2'h2 && wr_err === 1'b1) begin
            err = 1'b1;
            ok = 1'b1;
         end else if (kind == 2'h3 && byte_valid === 1'b1) begin
            data = {8'h00, byte_data};
            err = byte_err;
            ok = 1'b1;
         end
      end
   endtask
endmodule

/* File: dv/conveyor_motor_status_inputs_tb.sv */
`timescale 1ns/10ps
module conveyor_motor_status_inputs_tb;
   import conveyor_inputs_pkg::*;
   logic core_clk, resetn, sr, sl, rd_stb, map_eth, wr_stb, byte_stb;
   logic rd_valid, rd_err, wr_err, byte_valid, byte_err, e;
   logic [15:0] sup, lma, lhz, rma, rhz, fl, rd_addr, wr_addr, rd_data, d, w;
   logic [7:0] lmd, lbd, rmd, rbd, byte_idx, byte_data;
   logic [1:0] bk [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h3};
   logic [15:0] ba [6] = '{16'h06A5, 16'h06AF, 16'h0001, 16'h000B, 16'h0003, 16'h0016};
   int error_cnt, n_checks, it, n;
   bit ok;
   conveyor_motor_status_inputs #(.REFRESH_CYCLES(16'h0004)) conveyor_motor_status_inputs_inst (
      .CORE_CLK(core_clk), .RESETN(resetn), .SENSOR_RIGHT_PRESENT(sr), .SENSOR_LEFT_PRESENT(sl),
      .SUPPLY_MV(sup), .LEFT_MA(lma), .LEFT_HZ(lhz), .LEFT_MOTOR_DEGC(lmd), .LEFT_BOARD_DEGC(lbd),
      .LEFT_STATUS_CODE(fl[1:0]), .LEFT_DIGITAL_MODE(fl[2]), .BOARD_OVERHEAT(fl[5]),
      .LEFT_OVER_VOLT(fl[6]), .LEFT_LOW_VOLT(fl[7]), .LEFT_MOTOR_HOT(fl[8]),
      .LEFT_MAX_TORQUE(fl[9]), .LEFT_SHORT(fl[10]), .LEFT_NOT_CONNECTED(fl[11]),
      .LEFT_OVERLOAD(fl[12]), .LEFT_STALLED(fl[13]), .LEFT_HALL_FAULT(fl[14]),
      .LEFT_NOT_USED(fl[15]), .RIGHT_MA(rma), .RIGHT_HZ(rhz), .RIGHT_MOTOR_DEGC(rmd),
      .RIGHT_BOARD_DEGC(rbd), .RD_STB(rd_stb), .MAP_ETHERNET(map_eth), .RD_ADDR(rd_addr),
      .WR_STB(wr_stb), .WR_ADDR(wr_addr), .BYTE_STB(byte_stb), .BYTE_IDX(byte_idx),
      .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_ERR(rd_err), .WR_ERR(wr_err),
      .BYTE_DATA(byte_data), .BYTE_VALID(byte_valid), .BYTE_ERR(byte_err));
   plc_poller plc_poller_inst (
      .clk(core_clk), .rd_stb(rd_stb), .map_ethernet(map_eth), .rd_addr(rd_addr),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .byte_stb(byte_stb), .byte_idx(byte_idx),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err), .wr_err(wr_err),
      .byte_data(byte_data), .byte_valid(byte_valid), .byte_err(byte_err));
   // ------------------------------------------------------------
   // Expectations and comparisons
   // ------------------------------------------------------------
   function automatic logic [15:0] exp_word(input int k);
      case (k)
         0: return {14'h0000, sl, sr};
         1: return (sup > SUPPLY_MAX_MV) ? SUPPLY_MAX_MV : sup;
         2: return lma;
         3: return lhz;
         4: return {lmd, lbd};
         5: return fl & 16'hFFE7;
         6: return rma;
         7: return rhz;
         default: return {rmd, rbd};
      endcase
   endfunction
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_word(input string nm, input logic [15:0] ex, input logic [15:0] got);
      n_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic chk_flag(input string nm, input logic ex, input logic got);
      n_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", nm, ex, got);
      end
   endtask
   task automatic do_x(input logic [1:0] kind, input logic [15:0] addr);
      plc_poller_inst.xfer(kind, addr, d, e, ok);
      if (!ok) begin
         error_cnt++;
         $display("mismatch answer expected 1 seen 0");
         print_verdict();
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {resetn, sr, sl, sup, lma, lhz, rma, rhz, fl, lmd, lbd, rmd, rbd} = '0;
      error_cnt = 0;
      n_checks = 0;
      void'($urandom(32'h7120A29F));
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      for (it = 0; it < 8; it++) begin
         @(posedge core_clk);
         {sr, sl} <= 2'($urandom);
         sup <= (it == 0) ? 16'h88B8 : (it == 1) ? 16'h88B9 : (it == 2) ? 16'hFFFF : 16'($urandom);
         fl <= (it == 3) ? 16'hFFFF : (it == 4) ? 16'h0000 : 16'($urandom);
         {lma, lhz, rma, rhz} <= {32'($urandom), 32'($urandom)};
         {lmd, lbd, rmd, rbd} <= 32'($urandom);
         // Two and a half refresh periods let the new levels reach every snapshot.
         repeat (10) @(posedge core_clk);
         for (n = 0; n < 9; n++) begin
            w = exp_word(n);
            do_x(2'h0, SENSOR_PRESENCE_OFS + 16'(n));
            chk_word("reg_word", w, d);
            chk_flag("reg_err", 1'b0, e);
            do_x(2'h1, EIP_FIRST_INDEX + 16'(n));
            chk_word("index_word", w, d);
            chk_flag("index_err", 1'b0, e);
            do_x(2'h3, 16'(PN_FIRST_BYTE) + 16'(2 * n));
            chk_word("byte_hi", {8'h00, w[15:8]}, d);
            chk_flag("byte_hi_err", 1'b0, e);
            do_x(2'h3, 16'(PN_FIRST_BYTE) + 16'(2 * n + 1));
            chk_word("byte_lo", {8'h00, w[7:0]}, d);
            chk_flag("byte_lo_err", 1'b0, e);
         end
      end
      for (n = 0; n < 9; n++) begin
         do_x(2'h2, SENSOR_PRESENCE_OFS + 16'(n));
         chk_flag("wr_err", 1'b1, e);
         do_x(2'h0, SENSOR_PRESENCE_OFS);
         chk_word("after_write", exp_word(0), d);
      end
      for (n = 0; n < 6; n++) begin
         do_x(bk[n], ba[n]);
         chk_flag("unmapped_err", 1'b1, e);
         chk_word("unmapped_data", 16'h0000, d);
      end
      // A reset in mid-run clears the snapshots until the first capture.
      @(posedge core_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk_flag("reset_valid", 1'b0, rd_valid);
      resetn <= 1'b1;
      do_x(2'h0, LEFT_MOTOR_MILLIAMPS_OFS);
      chk_word("reset_word", 16'h0000, d);
      repeat (10) @(posedge core_clk);
      do_x(2'h0, LEFT_MOTOR_MILLIAMPS_OFS);
      chk_word("refresh_word", lma, d);
      print_verdict();
   end
endmodule
